// ### src/twmt_regs.vh
// register map, control bit positions, status codes and timing for the two-wire master transmitter
// assumes a byte-wide register port and a 200 MHz system clock
`ifndef TWMT_REGS_VH
`define TWMT_REGS_VH
`define TWMT_ADDR_CONTROL 2'h0
`define TWMT_ADDR_STATUS 2'h1
`define TWMT_ADDR_DATA 2'h2
`define TWMT_BIT_FLAG 7
`define TWMT_BIT_ACKEN 6
`define TWMT_BIT_START 5
`define TWMT_BIT_STOP 4
`define TWMT_BIT_WCOL 3
`define TWMT_BIT_EN 2
`define TWMT_BIT_IRQEN 0
`define TWMT_CTRL_RESET 8'h00
`define TWMT_DATA_RESET 8'hFF
`define TWMT_ST_START 8'h08
`define TWMT_ST_RSTART 8'h10
`define TWMT_ST_ADDR_ACK 8'h18
`define TWMT_ST_ADDR_NACK 8'h20
`define TWMT_ST_DATA_ACK 8'h28
`define TWMT_ST_DATA_NACK 8'h30
`define TWMT_ST_ARB_LOST 8'h38
`define TWMT_ST_IDLE 8'hF8
`define TWMT_ST_MR_ADDR 8'h40
`define TWMT_HALF_BIT_NS 16'h09C4
`define TWMT_CLK_NS 16'h0005
`define TWMT_HALF_CYCLES (`TWMT_HALF_BIT_NS / `TWMT_CLK_NS)
`endif

// ### src/twmt_master.v
// two-wire master transmitter: register port, bus sequencer, open-drain pins
// assumes pins pass through external pull-ups; slave may stretch the clock line
`timescale 1ns/1ps
`default_nettype none
`include "twmt_regs.vh"
module twmt_master
(
    input wire clk,
    input wire resetn,
    input wire [1:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWr,
    input wire regRd,
    output reg [7:0] regRdData,
    input wire sclIn,
    output reg sclOut,
    output reg sclOe,
    input wire sdaIn,
    output reg sdaOut,
    output reg sdaOe,
    input wire globalIrqEn,
    output reg irqReq
);
    localparam [3:0] S_IDLE = 4'h0;
    localparam [3:0] S_ST1 = 4'h1;
    localparam [3:0] S_ST2 = 4'h2;
    localparam [3:0] S_BITL = 4'h3;
    localparam [3:0] S_BITH = 4'h4;
    localparam [3:0] S_ACKL = 4'h5;
    localparam [3:0] S_ACKH = 4'h6;
    localparam [3:0] S_WAIT = 4'h7;
    localparam [3:0] S_SP1 = 4'h8;
    localparam [3:0] S_SP2 = 4'h9;
    localparam [3:0] S_SP3 = 4'hA;
    localparam [3:0] S_RS1 = 4'hB;
    localparam [15:0] HALF = `TWMT_HALF_CYCLES;

    reg rstMeta_reg, rstSync_reg;
    wire rstn;
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rstMeta_reg <= 1'b0;
            rstSync_reg <= 1'b0;
        end
        else
        begin
            rstMeta_reg <= 1'b1;
            rstSync_reg <= rstMeta_reg;
        end
    end
    assign rstn = rstSync_reg;

    // pins cross in through two flops; the first flop feeds nothing else
    reg sclMeta_reg, sclSync_reg, sdaMeta_reg, sdaSync_reg;
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sclMeta_reg <= 1'b1;
            sclSync_reg <= 1'b1;
            sdaMeta_reg <= 1'b1;
            sdaSync_reg <= 1'b1;
        end
        else
        begin
            sclMeta_reg <= sclIn;
            sclSync_reg <= sclMeta_reg;
            sdaMeta_reg <= sdaIn;
            sdaSync_reg <= sdaMeta_reg;
        end
    end

    reg [3:0] state_reg;
    reg [15:0] timer_reg;
    reg [2:0] bitCnt_reg;
    reg [7:0] shift_reg;
    reg flag_reg, ackEn_reg, start_reg, stop_reg, wcol_reg, en_reg, irqEn_reg;
    reg [7:0] data_reg;
    reg [7:0] status_reg;
    reg addrPhase_reg, busBusy_reg, masterMode_reg, sdaPrev_reg;

    wire [7:0] ctrlView;
    assign ctrlView = {flag_reg, ackEn_reg, start_reg, stop_reg, wcol_reg, en_reg, 1'b0,
                       irqEn_reg};
    wire ctrlWr;
    assign ctrlWr = regWr && (regAddr == `TWMT_ADDR_CONTROL);
    wire dataWr;
    assign dataWr = regWr && (regAddr == `TWMT_ADDR_DATA);
    wire flagClr;
    assign flagClr = ctrlWr && regWrData[`TWMT_BIT_FLAG];
    wire timeUp;
    assign timeUp = (timer_reg == 16'h0000);
    // a start seen on the bus marks it busy, including this master's own start; a stop frees it
    wire busStart;
    assign busStart = sclSync_reg && sdaPrev_reg && !sdaSync_reg;
    wire busStop;
    assign busStop = sclSync_reg && !sdaPrev_reg && sdaSync_reg;
    // free means no transfer open, own or foreign, and both lines read high
    wire busFree;
    assign busFree = !busBusy_reg && sclSync_reg && sdaSync_reg;

    reg setFlag;
    reg [7:0] newStatus;
    reg [3:0] state_next;
    reg stopDone;
    reg loadTimer;
    always @*
    begin
        setFlag = 1'b0;
        newStatus = status_reg;
        state_next = state_reg;
        stopDone = 1'b0;
        loadTimer = 1'b0;
        case (state_reg)
            S_IDLE:
            begin
                // act only once flag is clear and bus is free
                if (en_reg && !flag_reg && start_reg && busFree)
                begin
                    state_next = S_ST1;
                    loadTimer = 1'b1;
                end
            end
            S_ST1:
                // another master opened a transfer first: back off until the bus frees
                if (busStart && !masterMode_reg)
                    state_next = S_IDLE;
                else if (timeUp)
                begin
                    state_next = S_ST2;
                    loadTimer = 1'b1;
                end
            S_ST2:
                if (timeUp)
                begin
                    setFlag = 1'b1;
                    newStatus = masterMode_reg ? `TWMT_ST_RSTART : `TWMT_ST_START;
                    state_next = S_WAIT;
                end
            S_BITL:
                if (timeUp)
                begin
                    state_next = S_BITH;
                    loadTimer = 1'b1;
                end
            S_BITH:
                // slave may stretch: wait for the clock line to read high
                if (timeUp && sclSync_reg)
                begin
                    if (sdaSync_reg != shift_reg[7])
                    begin
                        setFlag = 1'b1;
                        newStatus = `TWMT_ST_ARB_LOST;
                        state_next = S_IDLE;
                    end
                    else
                    begin
                        state_next = (bitCnt_reg == 3'h7) ? S_ACKL : S_BITL;
                        loadTimer = 1'b1;
                    end
                end
            S_ACKL:
                if (timeUp)
                begin
                    state_next = S_ACKH;
                    loadTimer = 1'b1;
                end
            S_ACKH:
                if (timeUp && sclSync_reg)
                begin
                    setFlag = 1'b1;
                    state_next = S_WAIT;
                    // low on the ninth clock means acknowledge
                    if (addrPhase_reg)
                    begin
                        // a read address enters the receive side, not built here
                        if (data_reg[0])
                            newStatus = sdaSync_reg ? `TWMT_ST_IDLE : `TWMT_ST_MR_ADDR;
                        else
                            newStatus = sdaSync_reg ? `TWMT_ST_ADDR_NACK : `TWMT_ST_ADDR_ACK;
                    end
                    else
                        newStatus = sdaSync_reg ? `TWMT_ST_DATA_NACK : `TWMT_ST_DATA_ACK;
                end
            S_WAIT:
                if (!flag_reg && en_reg)
                begin
                    loadTimer = 1'b1;
                    if (stop_reg)
                        state_next = S_SP1;
                    else if (start_reg)
                        state_next = S_RS1;
                    else
                        state_next = S_BITL;
                end
            S_RS1:
                if (timeUp && sclSync_reg)
                begin
                    state_next = S_ST1;
                    loadTimer = 1'b1;
                end
            S_SP1:
                if (timeUp)
                begin
                    state_next = S_SP2;
                    loadTimer = 1'b1;
                end
            S_SP2:
                if (timeUp && sclSync_reg)
                begin
                    state_next = S_SP3;
                    loadTimer = 1'b1;
                end
            S_SP3:
                if (timeUp)
                begin
                    stopDone = 1'b1;
                    state_next = S_IDLE;
                end
            default:
                state_next = S_IDLE;
        endcase
        if (!en_reg)
            state_next = S_IDLE;
    end

    // after arbitration loss the flag stands in idle, so the clock line stays held
    wire flagNext;
    assign flagNext = setFlag || (flag_reg && !flagClr);

    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= S_IDLE;
            timer_reg <= 16'h0000;
            bitCnt_reg <= 3'h0;
            shift_reg <= 8'h00;
            {flag_reg, ackEn_reg, start_reg, stop_reg} <= 4'h0;
            {wcol_reg, en_reg, irqEn_reg} <= 3'h0;
            data_reg <= `TWMT_DATA_RESET;
            status_reg <= `TWMT_ST_IDLE;
            addrPhase_reg <= 1'b0;
            busBusy_reg <= 1'b0;
            masterMode_reg <= 1'b0;
            sdaPrev_reg <= 1'b1;
            regRdData <= 8'h00;
            sclOut <= 1'b0;
            sclOe <= 1'b0;
            sdaOut <= 1'b0;
            sdaOe <= 1'b0;
            irqReq <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            sdaPrev_reg <= sdaSync_reg;
            if (loadTimer)
                timer_reg <= HALF - 16'h0001;
            else if (!timeUp)
                timer_reg <= timer_reg - 16'h0001;
            if (busStart)
                busBusy_reg <= 1'b1;
            else if (busStop || !en_reg)
                busBusy_reg <= 1'b0;
            // flag: hardware set wins over a simultaneous clear
            if (setFlag)
                flag_reg <= 1'b1;
            else if (flagClr)
                flag_reg <= 1'b0;
            // modes other than master transmit are not built; status reads idle while the unit is disabled
            status_reg <= en_reg ? newStatus : `TWMT_ST_IDLE;
            if (ctrlWr)
            begin
                ackEn_reg <= regWrData[`TWMT_BIT_ACKEN];
                start_reg <= regWrData[`TWMT_BIT_START];
                stop_reg <= regWrData[`TWMT_BIT_STOP];
                en_reg <= regWrData[`TWMT_BIT_EN];
                irqEn_reg <= regWrData[`TWMT_BIT_IRQEN];
            end
            if (stopDone)
                stop_reg <= 1'b0;
            if (state_reg == S_ST2 && timeUp)
                start_reg <= 1'b0;
            // write collision set wins; write to the bit itself is ignored
            if (dataWr && !flag_reg)
                wcol_reg <= 1'b1;
            else if (dataWr)
                wcol_reg <= 1'b0;
            if (dataWr && flag_reg)
                data_reg <= regWrData;
            if (state_reg == S_ST2 && timeUp)
                masterMode_reg <= 1'b1;
            else if (stopDone || newStatus == `TWMT_ST_ARB_LOST || !en_reg)
                masterMode_reg <= 1'b0;
            if (state_reg == S_ST2)
                addrPhase_reg <= 1'b1;
            else if (state_reg == S_ACKH && setFlag)
                addrPhase_reg <= 1'b0;
            if (state_reg == S_WAIT && state_next == S_BITL)
            begin
                shift_reg <= data_reg;
                bitCnt_reg <= 3'h0;
            end
            else if (state_reg == S_BITH && state_next == S_BITL)
            begin
                shift_reg <= {shift_reg[6:0], 1'b0};
                bitCnt_reg <= bitCnt_reg + 3'h1;
            end
            // open drain: enable high pulls the line low
            sclOut <= 1'b0;
            sdaOut <= 1'b0;
            // data moves in the cycle the clock is pulled low; hold time is the pad delay only
            case (state_next)
                S_ST2: sdaOe <= 1'b1;
                S_BITL, S_BITH: sdaOe <= ~shift_reg[7];
                S_ACKL, S_ACKH, S_RS1: sdaOe <= 1'b0;
                S_SP1, S_SP2: sdaOe <= 1'b1;
                S_WAIT: sdaOe <= (newStatus == `TWMT_ST_START || newStatus == `TWMT_ST_RSTART);
                default: sdaOe <= 1'b0;
            endcase
            if (state_next == S_BITL && state_reg == S_BITH)
                sdaOe <= ~shift_reg[6];
            if (state_next == S_BITL && state_reg == S_WAIT)
                sdaOe <= ~data_reg[7];
            // clock held low while flag waits for software
            sclOe <= (state_next == S_WAIT) || (state_next == S_BITL) ||
                     (state_next == S_ACKL) || (state_next == S_SP1) ||
                     (en_reg && flagNext && state_next == S_IDLE);
            case (regAddr)
                `TWMT_ADDR_CONTROL: regRdData <= regRd ? ctrlView : 8'h00;
                `TWMT_ADDR_STATUS: regRdData <= regRd ? status_reg : 8'h00;
                `TWMT_ADDR_DATA: regRdData <= regRd ? data_reg : 8'h00;
                default: regRdData <= 8'h00;
            endcase
            irqReq <= irqEn_reg && globalIrqEn && flag_reg;
        end
    end
endmodule // twmt_master
`default_nettype wire

// ### verif/twmt_properties.sv
// port checker for the two-wire master transmitter
// assumes one clock domain; bound onto twmt_master below
`timescale 1ns/1ps
`default_nettype none
module twmt_properties
(
    input wire clk,
    input wire resetn,
    input wire [1:0] regAddr,
    input wire regRd,
    input wire logic [7:0] regRdData,
    input wire logic sclOut,
    input wire logic sclOe,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire globalIrqEn,
    input wire logic irqReq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence startSeen;
        $rose(sdaOe) && !sclOe;
    endsequence
    sequence stopSeen;
        $fell(sdaOe) && !sclOe;
    endsequence
    sequence busIdle8;
        (!sclOe && !sdaOe && !irqReq) [*8];
    endsequence
    read_idle_zero_a: assert property (!regRd |=> regRdData == 8'h00)
        else $error("read data not zero outside a read answer");
    read_unmapped_a: assert property (regRd && regAddr == 2'h3 |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    open_drain_a: assert property (!sclOut && !sdaOut)
        else $error("line driven high");
    reset_quiet_a: assert property ($rose(resetn) |-> !sclOe && !sdaOe ##1 !sclOe && !sdaOe)
        else $error("lines pulled right after reset");
    irq_gate_a: assert property (irqReq |-> $past(globalIrqEn))
        else $error("irq without global enable");
    irq_mask_a: assert property (!globalIrqEn |=> !irqReq)
        else $error("irq not masked");
    clock_hold_a: assert property (irqReq [*3] |-> sclOe)
        else $error("clock released while flag set");
    transfer_pause_a: assert property (irqReq [*3] |-> $stable(sdaOe))
        else $error("data line moved while suspended");
    // cycles since a start with the clock still released; one half bit is expected
    logic [10:0] startWait;
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            startWait <= 11'h000;
        else if (sclOe)
            startWait <= 11'h000;
        else if ((startWait != 11'h000) || $rose(sdaOe))
            startWait <= startWait + 11'h001;
    end
    start_clock_a: assert property (startWait <= 11'h44C)
        else $error("no clock low after start");
    start_hold_a: assert property (startSeen |=> sdaOe [*8])
        else $error("data line released right after start");
    stop_idle_a: assert property (stopSeen |=> busIdle8)
        else $error("bus or flag busy after stop");
endmodule // twmt_properties
bind twmt_master twmt_properties chk (.clk(clk), .resetn(resetn), .regAddr(regAddr),
    .regRd(regRd), .regRdData(regRdData), .sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .globalIrqEn(globalIrqEn), .irqReq(irqReq));
`default_nettype wire

// ### verif/twmt_slave_model.sv
// behavioural slave receiver: acks its own write address and then its data bytes
// assumes the bench resolves both lines as wired-and with pull-ups
`timescale 1ns/1ps
`default_nettype none
module twmt_slave_model
#(
    parameter logic [6:0] OWN_ADDR = 7'h50
)
(
    input wire logic scl,
    input wire logic sda,
    output logic sdaPull,
    output logic [7:0] lastByte,
    output int nStop
);
    logic [7:0] shiftReg;
    logic startSeen;
    logic first;
    logic sel;
    initial
    begin
        sdaPull = 1'b0;
        lastByte = 8'h00;
        nStop = 0;
        startSeen = 1'b0;
        sel = 1'b0;
    end
    // a start restarts the receiver even mid byte, so repeated starts resync
    // data may move in the same step as the clock falls: judge the lines once settled
    always @(negedge sda)
    begin
        #1;
        if (scl === 1'b1 && sda === 1'b0)
        begin
            disable rx;
            startSeen = 1'b1;
        end
    end
    always @(posedge sda)
    begin
        #1;
        if (scl === 1'b1 && sda === 1'b1)
        begin
            disable rx;
            nStop = nStop + 1;
        end
    end
    always
    begin : rx
        sdaPull = 1'b0;
        wait (startSeen === 1'b1);
        startSeen = 1'b0;
        first = 1'b1;
        forever
        begin
            repeat (8)
            begin
                @(posedge scl);
                shiftReg = {shiftReg[6:0], sda};
            end
            @(negedge scl);
            if (first)
                sel = (shiftReg[7:1] == OWN_ADDR) && !shiftReg[0];
            else if (sel)
                lastByte = shiftReg;
            sdaPull = sel;
            @(negedge scl);
            sdaPull = 1'b0;
            first = 1'b0;
        end
    end
endmodule // twmt_slave_model
`default_nettype wire

// ### verif/tb.sv
// self-checking bench: register-port sequences through whole write transfers
// assumes the slave model on the bus and the bound port checker
`timescale 1ns/1ps
`default_nettype none
`include "twmt_regs.vh"
module tb;
    logic clk;
    logic resetn;
    logic [1:0] regAddr;
    logic [7:0] regWrData;
    logic regWr;
    logic regRd;
    logic globalIrqEn;
    logic [7:0] rdVal;
    wire [7:0] regRdData;
    wire sclOe, sdaOe, irqReq, sdaPull;
    wire [7:0] lastByte;
    int nStop;
    int stopBase;
    int nMismatch = 0;
    int nTests = 0;
    wire scl = ~sclOe;
    wire sda = ~(sdaOe | sdaPull);
    twmt_master uut (.clk(clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .sclIn(scl), .sclOut(),
        .sclOe(sclOe), .sdaIn(sda), .sdaOut(), .sdaOe(sdaOe), .globalIrqEn(globalIrqEn),
        .irqReq(irqReq));
    twmt_slave_model slave (.scl(scl), .sda(sda), .sdaPull(sdaPull), .lastByte(lastByte),
        .nStop(nStop));
    task automatic finalReport();
        if (nMismatch == 0 && nTests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        nTests++;
        if (seen !== exp)
        begin
            nMismatch++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        rdVal = regRdData;
    endtask
    // bounded poll; one transfer step lasts about nine bit times
    task automatic waitCtrl(input logic [7:0] mask, input logic [7:0] val);
        for (int i = 0; i < 8000; i++)
        begin
            rd(`TWMT_ADDR_CONTROL);
            if ((rdVal & mask) === val)
                break;
        end
        check("control wait", rdVal & mask, val);
    endtask
    task automatic step(input logic [7:0] ctrl, input logic [7:0] st);
        wr(`TWMT_ADDR_CONTROL, ctrl);
        waitCtrl(8'h80, 8'h80);
        rd(`TWMT_ADDR_STATUS);
        check("status", rdVal & 8'hF8, st);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial
    begin
        repeat (95000) @(posedge clk);
        nMismatch++;
        finalReport();
    end
    initial
    begin
        resetn = 1'b0;
        regAddr = 2'h0;
        regWrData = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        globalIrqEn = 1'b1;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        rd(`TWMT_ADDR_CONTROL);
        check("control reset", rdVal, `TWMT_CTRL_RESET);
        rd(`TWMT_ADDR_STATUS);
        check("status reset", rdVal, `TWMT_ST_IDLE);
        rd(`TWMT_ADDR_DATA);
        check("data reset", rdVal, `TWMT_DATA_RESET);
        rd(2'h3);
        check("unmapped", rdVal, 8'h00);
        wr(`TWMT_ADDR_DATA, 8'h11);
        rd(`TWMT_ADDR_CONTROL);
        check("collision", rdVal & 8'h08, 8'h08);
        rd(`TWMT_ADDR_DATA);
        check("dropped write", rdVal, `TWMT_DATA_RESET);
        step(8'hA5, `TWMT_ST_START);
        check("irq on", {7'h00, irqReq}, 8'h01);
        @(posedge clk);
        globalIrqEn <= 1'b0;
        repeat (3) @(posedge clk);
        check("irq masked", {7'h00, irqReq}, 8'h00);
        globalIrqEn <= 1'b1;
        wr(`TWMT_ADDR_CONTROL, 8'h05);
        rd(`TWMT_ADDR_CONTROL);
        check("flag kept", rdVal & 8'h80, 8'h80);
        wr(`TWMT_ADDR_DATA, 8'hA0);
        rd(`TWMT_ADDR_CONTROL);
        check("collision cleared", rdVal & 8'h08, 8'h00);
        step(8'h84, `TWMT_ST_ADDR_ACK);
        wr(`TWMT_ADDR_DATA, 8'h5A);
        step(8'h84, `TWMT_ST_DATA_ACK);
        check("slave byte", lastByte, 8'h5A);
        step(8'hA4, `TWMT_ST_RSTART);
        wr(`TWMT_ADDR_DATA, 8'hA2);
        step(8'h84, `TWMT_ST_ADDR_NACK);
        wr(`TWMT_ADDR_DATA, 8'h3C);
        step(8'h84, `TWMT_ST_DATA_NACK);
        stopBase = nStop;
        wr(`TWMT_ADDR_CONTROL, 8'h94);
        waitCtrl(8'h10, 8'h00);
        check("no flag", rdVal & 8'h80, 8'h00);
        check("stop seen", 8'(nStop - stopBase), 8'h01);
        step(8'hA4, `TWMT_ST_START);
        wr(`TWMT_ADDR_DATA, 8'hA1);
        step(8'h84, `TWMT_ST_IDLE);
        wr(`TWMT_ADDR_CONTROL, 8'h94);
        waitCtrl(8'h10, 8'h00);
        finalReport();
    end
endmodule // tb
`default_nettype wire
